//--- verification/fhcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fhcr_host_model
  import fhcr_pkg::*;
(
  input  wire logic                    ref_clk,       // Clock.
  output logic                         reg_sel,       // Strobe.
  output logic                         reg_wr,        // Write.
  output logic                         reg_addr_load, // Load.
  output fhcr_pkg::fhcr_addr_type      reg_addr,      // Address.
  output fhcr_pkg::fhcr_byte_type      reg_wdata,     // Data out.
  input  wire logic                    reg_ack,       // Done.
  input  wire fhcr_pkg::fhcr_byte_type reg_rdata      // Data in.
);
  int lost = 0;
  initial begin
    reg_sel = 1'b0;
    reg_wr = 1'b0;
    reg_addr_load = 1'b1;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  // Released lines show the inverse so a stale value is never mistaken for data.
  task automatic acc(input logic w, input fhcr_addr_type a, input fhcr_byte_type d,
                     output fhcr_byte_type q);
    int n;
    @(posedge ref_clk);
    reg_sel <= 1'b1;
    reg_wr <= w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_sel <= 1'b0;
    reg_wr <= ~w;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    for (n = 0; n < 4; n++) begin
      @(posedge ref_clk);
      if (reg_ack === 1'b1) break;
    end
    if (n == 4) lost++;
    q = reg_rdata;
  endtask : acc
endmodule : fhcr_host_model
`default_nettype wire

//--- verification/fhcr_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fhcr_top_properties
  import fhcr_pkg::*;
(
  input wire logic                     ref_clk,            // Clock.
  input wire logic                     rst_b,              // Reset.
  input wire logic                     reg_sel,            // Strobe.
  input wire logic                     reg_wr,             // Write.
  input wire logic                     reg_addr_load,      // Load.
  input wire fhcr_pkg::fhcr_addr_type  reg_addr,           // Address.
  input wire fhcr_pkg::fhcr_byte_type  reg_wdata,          // Data in.
  input wire logic                     reg_ack,            // Done.
  input wire fhcr_pkg::fhcr_byte_type  reg_rdata,          // Data out.
  input wire fhcr_pkg::fhcr_addr_type  addr_ptr,           // Pointer.
  input wire logic                     device_power_down,  // Standby.
  input wire logic                     radio_power_down,   // Radio off.
  input wire logic [4:0]               command_code,       // Command.
  input wire logic                     host_owns_bus,      // Host.
  input wire logic                     module_owns_bus,    // Module.
  input wire fhcr_pkg::fhcr_link_type  module_link_select, // Link.
  input wire logic                     upper_fill_warning, // Upper.
  input wire logic                     lower_fill_warning, // Lower.
  input wire fhcr_pkg::fhcr_count_type fill_count          // Count.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [8:0] wm_r;
  logic       sm_r;
  wire logic [6:0] ea = reg_addr_load ? reg_addr : addr_ptr;
  wire logic       w_en = reg_sel && reg_wr;
  // In the small buffer mode the watermark msb is ignored.
  wire logic [9:0] wm_e = sm_r ? {2'h0, wm_r[7:0]} : {1'b0, wm_r};
  wire logic [9:0] sz = sm_r ? 10'h0ff : 10'h200;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wm_r <= 9'h000;
      sm_r <= 1'b0;
    end else if (w_en && ea == 7'h03) begin
      wm_r[7:0] <= reg_wdata;
    end else if (w_en && ea == 7'h02) begin
      wm_r[8] <= reg_wdata[2];
      sm_r    <= reg_wdata[7];
    end
  end
  property p_no_both; !(host_owns_bus && module_owns_bus); endproperty
  a_no_both: assert property (p_no_both) else $error("both owners set");
  property p_ptr_hold; reg_sel && ea == 7'h05 |=> addr_ptr == $past(ea); endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");
  property p_ptr_step; reg_sel && ea != 7'h05 |=> addr_ptr == $past(ea) + 7'h01; endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer not advanced");
  property p_fill_up;
    w_en && ea == 7'h05 && fill_count < 10'h0ff |=> fill_count == $past(fill_count) + 10'h001;
  endproperty
  a_fill_up: assert property (p_fill_up) else $error("count not incremented");
  property p_cmd; w_en && ea == 7'h00 |=> {device_power_down, radio_power_down, command_code}
    == {$past(reg_wdata[7:6]), $past(reg_wdata[4:0])}; endproperty
  a_cmd: assert property (p_cmd) else $error("command outputs wrong");
  property p_ctrl_rd; reg_sel && !reg_wr && ea == 7'h02 |=>
    !reg_rdata[4] && reg_rdata[1:0] == $past(fill_count[9:8]); endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read wrong");
  property p_warn; lower_fill_warning == (fill_count <= wm_e) &&
    upper_fill_warning == (sz - fill_count <= wm_e); endproperty
  a_warn: assert property (p_warn) else $error("fill warning wrong");
  property p_both_ref; w_en && ea == 7'h01 && reg_wdata[6] && reg_wdata[5] |=>
    $stable(host_owns_bus) && $stable(module_owns_bus); endproperty
  a_both_ref: assert property (p_both_ref) else $error("owner write not refused");
endmodule : fhcr_top_properties
bind fhcr_top fhcr_top_properties u_props (.ref_clk, .rst_b, .reg_sel, .reg_wr, .reg_addr_load,
  .reg_addr, .reg_wdata, .reg_ack, .reg_rdata, .addr_ptr, .device_power_down, .radio_power_down,
  .command_code, .host_owns_bus, .module_owns_bus, .module_link_select, .upper_fill_warning,
  .lower_fill_warning, .fill_count);
`default_nettype wire

//--- verification/fifo_host_control_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_host_control_regs_tb_top;
  import fhcr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_sel, reg_wr, reg_addr_load, reg_ack, device_power_down, radio_power_down;
  logic host_owns_bus, module_owns_bus, upper_fill_warning, lower_fill_warning;
  logic [4:0] command_code;
  fhcr_addr_type reg_addr, addr_ptr;
  fhcr_byte_type reg_wdata, reg_rdata, q;
  fhcr_link_type module_link_select;
  fhcr_count_type fill_count;
  int num_errors = 0;
  int num_checks = 0;
  always #25 ref_clk = ~ref_clk;
  fhcr_top dut (.ref_clk, .rst_b, .reg_sel, .reg_wr, .reg_addr_load, .reg_addr, .reg_wdata,
    .reg_ack, .reg_rdata, .addr_ptr, .device_power_down, .radio_power_down, .command_code,
    .host_owns_bus, .module_owns_bus, .module_link_select, .upper_fill_warning,
    .lower_fill_warning, .fill_count);
  fhcr_host_model host (.ref_clk, .reg_sel, .reg_wr, .reg_addr_load, .reg_addr, .reg_wdata,
    .reg_ack, .reg_rdata);
  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input fhcr_addr_type a, input fhcr_byte_type d);
    host.acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input fhcr_addr_type a);
    host.acc(1'b0, a, 8'h00, q);
  endtask : rd
  task automatic stop_test();
    num_errors += host.lost;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  fhcr_byte_type cmds[4] = '{8'h80, 8'h40, 8'h3f, 8'h1f};
  fhcr_byte_type own[10] = '{8'h40, 8'h80, 8'h60, 8'h80, 8'h40, 8'h20, 8'h80, 8'h2c, 8'h04, 8'h08};
  logic [1:0] ex[10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0};
  initial begin
    logic [9:0] n;
    int sz;
    int wm;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(7'h02);
    chk("control", {2'h0, q}, 10'h020);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      wr(7'h00, cmds[i]);
      chk("command", {2'h0, device_power_down, radio_power_down, 1'b0, command_code},
        {2'h0, cmds[i][7:6], 1'b0, cmds[i][4:0]});
      chk("pointer", {3'h0, addr_ptr}, 10'h001);
    end
    $display("command test done");
    // Clearing an ownership bit needs no unlock; only setting one does.
    for (int i = 0; i < 10; i++) begin
      wr(7'h01, own[i]);
      chk("owner", {6'h00, host_owns_bus, module_owns_bus, module_link_select},
        {6'h00, ex[i], own[i][3:2]});
    end
    wr(7'h01, 8'h80);
    rd(7'h01);
    chk("unlock", {2'h0, q}, 10'h080);
    wr(7'h03, 8'h10);
    rd(7'h03);
    chk("watermark", {2'h0, q}, 10'h010);
    rd(7'h01);
    chk("unlock", {2'h0, q}, 10'h000);
    wr(7'h01, 8'h40);
    chk("owner", {8'h00, host_owns_bus, module_owns_bus}, 10'h000);
    $display("owner test done");
    for (int m = 0; m < 2; m++) begin
      sz = m ? 255 : 512;
      wm = m ? 16 : 272;
      wr(7'h02, 8'h10);
      wr(7'h02, m ? 8'h84 : 8'h04);
      wr(7'h03, 8'h10);
      for (int c = 1; c <= sz + 1; c++) begin
        wr(7'h05, c[7:0]);
        n = 10'((c > sz) ? sz : c);
        chk("count", fill_count, n);
        chk("warnings", {8'h00, upper_fill_warning, lower_fill_warning},
          {8'h00, 1'(sz - n <= wm), 1'(n <= wm)});
      end
      chk("pointer", {3'h0, addr_ptr}, 10'h005);
      rd(7'h02);
      chk("control", {7'h00, q[4], q[1:0]}, {7'h00, 1'b0, n[9:8]});
      rd(7'h04);
      chk("length", {2'h0, q}, {2'h0, n[7:0]});
      rd(7'h05);
      chk("data", {2'h0, q}, 10'h001);
      chk("count", fill_count, n - 10'h001);
      wr(7'h02, 8'h10);
      chk("count", fill_count, 10'h000);
      rd(7'h05);
      chk("empty count", fill_count, 10'h000);
      chk("empty data", {2'h0, q}, 10'h000);
    end
    $display("buffer test done");
    stop_test();
  end
endmodule : fifo_host_control_regs_tb_top
`default_nettype wire

//--- verilog/fhcr_cfg.svh
`ifndef FHCR_CFG_SVH
`define FHCR_CFG_SVH
`define FHCR_ADDR_COMMAND      7'h00
`define FHCR_ADDR_OWNER        7'h01
`define FHCR_ADDR_BUFCTRL      7'h02
`define FHCR_ADDR_WATERMARK    7'h03
`define FHCR_ADDR_FILL         7'h04
`define FHCR_ADDR_DATA         7'h05
`define FHCR_CMD_STANDBY_BIT   7
`define FHCR_CMD_RADIO_OFF_BIT 6
`define FHCR_CMD_CODE_MSB      4
`define FHCR_OWN_UNLOCK_BIT    7
`define FHCR_OWN_HOST_BIT      6
`define FHCR_OWN_MODULE_BIT    5
`define FHCR_OWN_LINK_MSB      3
`define FHCR_OWN_LINK_LSB      2
`define FHCR_BC_SIZE_BIT       7
`define FHCR_BC_UPPER_BIT      6
`define FHCR_BC_LOWER_BIT      5
`define FHCR_BC_CLEAR_BIT      4
`define FHCR_BC_WM_MSB_BIT     2
`define FHCR_SIZE_SMALL        10'h0ff
`define FHCR_SIZE_LARGE        10'h200
`define FHCR_DEPTH             512
`define FHCR_RST_COMMAND       8'h00
`define FHCR_RST_OWNER         8'h00
`define FHCR_RST_WATERMARK     8'h00
`define FHCR_RST_ADDR          7'h00
`define FHCR_RST_SIZE_SMALL    1'b0
`define FHCR_RST_WM_MSB        1'b0
`define FHCR_RST_COUNT         10'h000
`define FHCR_RST_RDATA         8'h00
`endif

//--- verilog/fhcr_pkg.sv
package fhcr_pkg;
  typedef logic [6:0] fhcr_addr_type;
  typedef logic [7:0] fhcr_byte_type;
  typedef logic [9:0] fhcr_count_type;
  typedef enum logic [1:0] {
    FHCR_LINK_OFF      = 2'h0,
    FHCR_LINK_SPI      = 2'h1,
    FHCR_LINK_TWO_SLOW = 2'h2,
    FHCR_LINK_TWO_STD  = 2'h3
  } fhcr_link_type;
endpackage : fhcr_pkg

//--- verilog/fhcr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fhcr_cfg.svh"

module fhcr_top
  import fhcr_pkg::*;
(
  input  wire logic                    ref_clk,          // System clock, 20 MHz.
  input  wire logic                    rst_b,            // Asynchronous reset, active low.
  input  wire logic                    reg_sel,          // Register access strobe.
  input  wire logic                    reg_wr,           // One writes, zero reads.
  input  wire logic                    reg_addr_load,    // Loads the address pointer.
  input  wire fhcr_pkg::fhcr_addr_type reg_addr,         // Address to load.
  input  wire fhcr_pkg::fhcr_byte_type reg_wdata,        // Write data.
  output logic                         reg_ack,          // Access done, one cycle.
  output fhcr_pkg::fhcr_byte_type      reg_rdata,        // Read data.
  output fhcr_pkg::fhcr_addr_type      addr_ptr,         // Current address pointer.
  output logic                         device_power_down,// Power-down state.
  output logic                         radio_power_down, // Receiver and transmitter off.
  output logic [4:0]                   command_code,     // Selected command code.
  output logic                         host_owns_bus,    // Host owns the bus.
  output logic                         module_owns_bus,  // Module owns the bus.
  output fhcr_pkg::fhcr_link_type      module_link_select,// Module interface choice.
  output logic                         upper_fill_warning,// Upper fill warning.
  output logic                         lower_fill_warning,// Lower fill warning.
  output fhcr_pkg::fhcr_count_type     fill_count        // Bytes held.
);
  import fhcr_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  function automatic logic fhcr_hit(input fhcr_addr_type a, input logic [6:0] b);
    fhcr_hit = (a == b);
  endfunction : fhcr_hit

  // Ring pointers wrap at the selected size. A size change while bytes are held
  // scrambles their order, which is why software clears the buffer first.
  function automatic fhcr_count_type fhcr_wrap_inc(input fhcr_count_type p,
                                                  input fhcr_count_type lim);
    fhcr_wrap_inc = (p == fhcr_count_type'(lim - 10'h001)) ? 10'h000
                  : fhcr_count_type'(p + 10'h001);
  endfunction : fhcr_wrap_inc

  fhcr_addr_type  ptr_r;
  fhcr_addr_type  ptr_nxt;
  fhcr_addr_type  cur_addr;
  fhcr_count_type count_r;
  fhcr_count_type count_nxt;
  fhcr_count_type size_now;
  fhcr_count_type wm_full;
  fhcr_count_type head_r;
  fhcr_count_type tail_r;
  fhcr_byte_type  cmd_r;
  fhcr_byte_type  own_r;
  fhcr_byte_type  wm_r;
  logic           size_small_r;
  logic           wm_msb_r;
  fhcr_byte_type  mem [`FHCR_DEPTH];
  fhcr_byte_type  rd_mux;

  assign cur_addr = reg_addr_load ? reg_addr : ptr_r;

  wire wr_any  = reg_sel && reg_wr;
  wire rd_any  = reg_sel && !reg_wr;
  wire wr_cmd  = wr_any && fhcr_hit(cur_addr, `FHCR_ADDR_COMMAND);
  wire wr_own  = wr_any && fhcr_hit(cur_addr, `FHCR_ADDR_OWNER);
  wire wr_bc   = wr_any && fhcr_hit(cur_addr, `FHCR_ADDR_BUFCTRL);
  wire wr_wm   = wr_any && fhcr_hit(cur_addr, `FHCR_ADDR_WATERMARK);
  wire is_data = fhcr_hit(cur_addr, `FHCR_ADDR_DATA);
  wire flush   = wr_bc && reg_wdata[`FHCR_BC_CLEAR_BIT];
  wire full    = (count_r >= size_now);
  wire empty   = (count_r == 10'h000);
  // Overfilling or overdrawing is dropped; the count never wraps.
  wire push    = wr_any && is_data && !full && !flush;
  wire pop     = rd_any && is_data && !empty;

  // ----------------------------------------------------------------
  // Address pointer
  // ----------------------------------------------------------------
  assign ptr_nxt = !reg_sel ? cur_addr
                 : is_data  ? cur_addr
                 : fhcr_addr_type'(cur_addr + 7'h01);

  // ----------------------------------------------------------------
  // Ownership arbitration
  // ----------------------------------------------------------------
  wire own_req_host = reg_wdata[`FHCR_OWN_HOST_BIT];
  wire own_req_mod  = reg_wdata[`FHCR_OWN_MODULE_BIT];
  wire own_unlocked = own_r[`FHCR_OWN_UNLOCK_BIT];
  // Setting a bit needs a prior unlock; a request for both is refused whole.
  wire own_sets     = (own_req_host && !own_r[`FHCR_OWN_HOST_BIT]) ||
                      (own_req_mod && !own_r[`FHCR_OWN_MODULE_BIT]);
  wire own_ok       = !(own_req_host && own_req_mod) &&
                      (own_unlocked || !own_sets);
  fhcr_byte_type own_nxt;
  always_comb begin
    own_nxt = own_r;
    if (wr_own) begin
      own_nxt[`FHCR_OWN_UNLOCK_BIT] = reg_wdata[`FHCR_OWN_UNLOCK_BIT];
      own_nxt[`FHCR_OWN_LINK_MSB:`FHCR_OWN_LINK_LSB] =
        reg_wdata[`FHCR_OWN_LINK_MSB:`FHCR_OWN_LINK_LSB];
      if (own_ok) begin
        own_nxt[`FHCR_OWN_HOST_BIT]   = own_req_host;
        own_nxt[`FHCR_OWN_MODULE_BIT] = own_req_mod;
      end
    end else if (wr_any && own_unlocked) begin
      own_nxt[`FHCR_OWN_UNLOCK_BIT] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Fill level and warnings
  // ----------------------------------------------------------------
  assign size_now  = size_small_r ? `FHCR_SIZE_SMALL : `FHCR_SIZE_LARGE;
  assign wm_full   = {1'b0, (wm_msb_r && !size_small_r), wm_r};
  assign count_nxt = flush ? 10'h000
                   : (push && !pop) ? fhcr_count_type'(count_r + 10'h001)
                   : (pop && !push) ? fhcr_count_type'(count_r - 10'h001)
                   : count_r;
  wire fhcr_upper = fhcr_count_type'(size_now - count_r) <= wm_full;
  wire fhcr_lower = count_r <= wm_full;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    unique case (cur_addr)
      `FHCR_ADDR_COMMAND:   rd_mux = {cmd_r[7:6], 1'b0, cmd_r[4:0]};
      `FHCR_ADDR_OWNER:     rd_mux = {own_r[7:5], 1'b0, own_r[3:2], 2'h0};
      `FHCR_ADDR_BUFCTRL:   rd_mux = {size_small_r, fhcr_upper, fhcr_lower, 1'b0,
                                      1'b0, wm_msb_r, count_r[9:8]};
      `FHCR_ADDR_WATERMARK: rd_mux = wm_r;
      `FHCR_ADDR_FILL:      rd_mux = count_r[7:0];
      `FHCR_ADDR_DATA:      rd_mux = empty ? 8'h00 : mem[tail_r[8:0]];
      default:              rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  fhcr_byte_type  cmd_nxt;
  fhcr_byte_type  wm_nxt;
  fhcr_byte_type  rdata_nxt;
  fhcr_count_type head_nxt;
  fhcr_count_type tail_nxt;
  logic           size_small_nxt;
  logic           wm_msb_nxt;
  logic           ack_nxt;

  // The reserved command bit is stored as zero so that it always reads back zero.
  assign cmd_nxt        = wr_cmd ? {reg_wdata[7:6], 1'b0, reg_wdata[4:0]}
                                 : cmd_r;
  assign wm_nxt         = wr_wm ? reg_wdata : wm_r;
  assign size_small_nxt = wr_bc ? reg_wdata[`FHCR_BC_SIZE_BIT] : size_small_r;
  assign wm_msb_nxt     = wr_bc ? reg_wdata[`FHCR_BC_WM_MSB_BIT] : wm_msb_r;
  // Flush restarts both ring pointers together; the buffer reads empty because flush also zeroes the count.
  assign head_nxt       = flush ? `FHCR_RST_COUNT
                        : push  ? fhcr_wrap_inc(head_r, size_now)
                        : head_r;
  assign tail_nxt       = flush ? `FHCR_RST_COUNT
                        : pop   ? fhcr_wrap_inc(tail_r, size_now)
                        : tail_r;
  assign ack_nxt        = reg_sel;
  assign rdata_nxt      = rd_any ? rd_mux : reg_rdata;

  // ----------------------------------------------------------------
  // Address pointer register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ptr_r <= `FHCR_RST_ADDR;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cmd_r <= `FHCR_RST_COMMAND;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Ownership register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      own_r <= `FHCR_RST_OWNER;
    end else begin
      own_r <= own_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Watermark register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      wm_r <= `FHCR_RST_WATERMARK;
    end else begin
      wm_r <= wm_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Buffer size selection
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      size_small_r <= `FHCR_RST_SIZE_SMALL;
    end else begin
      size_small_r <= size_small_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Watermark extension bit
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      wm_msb_r <= `FHCR_RST_WM_MSB;
    end else begin
      wm_msb_r <= wm_msb_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Fill count
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      count_r <= `FHCR_RST_COUNT;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Write pointer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      head_r <= `FHCR_RST_COUNT;
    end else begin
      head_r <= head_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read pointer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      tail_r <= `FHCR_RST_COUNT;
    end else begin
      tail_r <= tail_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Access acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_ack <= 1'b0;
    end else begin
      reg_ack <= ack_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata <= `FHCR_RST_RDATA;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // Storage has no reset so that it maps onto plain RAM.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[head_r[8:0]] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign addr_ptr           = ptr_r;
  assign device_power_down  = cmd_r[`FHCR_CMD_STANDBY_BIT];
  assign radio_power_down   = cmd_r[`FHCR_CMD_RADIO_OFF_BIT];
  assign command_code       = cmd_r[`FHCR_CMD_CODE_MSB:0];
  assign host_owns_bus      = own_r[`FHCR_OWN_HOST_BIT];
  assign module_owns_bus    = own_r[`FHCR_OWN_MODULE_BIT];
  assign module_link_select = fhcr_link_type'(own_r[`FHCR_OWN_LINK_MSB:`FHCR_OWN_LINK_LSB]);
  assign upper_fill_warning = fhcr_upper;
  assign lower_fill_warning = fhcr_lower;
  assign fill_count         = count_r;

endmodule : fhcr_top
`default_nettype wire
